/* File: design/decode_regs.svh */
// register offsets, status bit positions and reset values
// assumes a 32-bit AHB-Lite slave decoding haddr[7:0]
`ifndef DECODE_REGS_SVH
`define DECODE_REGS_SVH
`define INSTR_OFS 8'h00
`define STAT_OFS 8'h04
`define LOCAL_STORE_OFS 8'h40
`define ST_BUSY 0
`define ST_INVAL 1
`define ST_CARRY 2
`define ST_ZERO 3
`define ST_ONES 4
`define ST_LOW 5
`define INSTR_RST 16'h0000
`define INC_ONE 16'h0001
`define INC_TWO 16'h0002
`define DEC_ONE 16'hFFFF
`endif

/* File: design/decode_pkg.sv */
// types shared by the service processor decoder and its bench
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package decode_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_MEM = 3'b100
  } fsm_t;
  typedef enum logic [1:0] {
    SP_MAIN = 2'b00,
    SP_CTRL = 2'b01,
    SP_MPROC = 2'b10
  } space_t;
  typedef enum logic [1:0] {
    LN_LOW = 2'b00,
    LN_HIGH = 2'b01,
    LN_WORD = 2'b10
  } lane_t;
  typedef struct packed {
    logic req;
    logic write;
    logic wide;
    space_t space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } mem_ans_t;
  typedef struct packed {
    logic low;
    logic ones;
    logic zero;
    logic carry;
  } flags_t;
  typedef struct packed {
    fsm_t fsm;
    logic [15:0] instr;
    mem_req_t mem;
    logic ldEn;
    logic [2:0] ldReg;
    lane_t ldLane;
    logic updEn;
    logic [2:0] updReg;
    logic [15:0] delta;
    flags_t flags;
    logic invalid;
    logic [7:0][15:0] localStoreReg;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } state_t;
endpackage
`default_nettype wire

/* File: design/service_decode.sv */
// service processor decoder for opcodes 4 to 7, with AHB-Lite registers
// assumes one clock; storage partner answers on memAns in the same domain
//
// Behaviour
// - sub-op 8 loads main byte, optional increment
// - sub-op 9 reads processor or main byte
// - sub-op A loads control word or byte
// - sub-op b low reads word, decrements
// - sub-op b high: main pair or control byte
// - sub-op C stores main byte, optional increment
// - sub-op d writes chosen byte, decrements
// - sub-op E stores to control storage
// - sub-op F low writes word, decrements
// - sub-op F high: main pair or control byte
// - opcode 5 tests register byte with mask
// - sub-op 0 adds field plus one
// - sub-op 8 subtracts field plus one
// - sub-ops 1 to 7 logical and compare
// - sub-ops 9, b, C, E arithmetic
// - shift left is add to itself
// - opcode 7 mixed width subtract and add
// - opcode 7 immediate processor register transfer
// - select bits choose work register and byte
`default_nettype none
`include "decode_regs.svh"
module service_decode (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // storage and processor register port
  output decode_pkg::mem_req_t memReq,
  input wire decode_pkg::mem_ans_t memAns
);
  import decode_pkg::*;

  state_t s_ff;
  state_t nxt_s;

  assign hreadyout = s_ff.hready;
  assign hresp = s_ff.hresp;
  assign hrdata = s_ff.hrdata;
  assign memReq = s_ff.mem;

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic [3:0] op;
    logic xb;
    logic [2:0] dataRegSel;
    logic [3:0] sub;
    logic b12;
    logic [2:0] addrRegSel;
    logic [15:0] aW;
    logic [15:0] bW;
    logic [7:0] bSel;
    logic [15:0] a;
    logic [15:0] b;
    logic [16:0] r17;
    logic [15:0] res;
    logic cin;
    logic aluOk;
    logic aluWr;
    logic arith;
    logic dOk;
    logic dWr;
    logic dWide;
    space_t dSp;
    lane_t dLane;
    logic [15:0] dDelta;
    logic [7:0] tByte;
    logic [31:0] rdv;
    logic [15:0] ld;
    logic addrPh;
    op = s_ff.instr[15:12];
    xb = s_ff.instr[11];
    dataRegSel = s_ff.instr[10:8];
    sub = s_ff.instr[7:4];
    b12 = s_ff.instr[3];
    addrRegSel = s_ff.instr[2:0];
    aW = s_ff.localStoreReg[dataRegSel];
    bW = s_ff.localStoreReg[addrRegSel];
    bSel = b12 ? bW[15:8] : bW[7:0];
    a = '0;
    b = '0;
    r17 = '0;
    res = '0;
    cin = 1'b0;
    aluOk = 1'b1;
    aluWr = 1'b1;
    arith = 1'b0;
    dOk = 1'b1;
    dWr = 1'b0;
    dWide = 1'b0;
    dSp = SP_MAIN;
    dLane = LN_LOW;
    dDelta = '0;
    tByte = xb ? aW[15:8] : aW[7:0];
    rdv = '0;
    ld = '0;
    addrPh = hsel & htrans[1] & hready;
    nxt_s = s_ff;
    nxt_s.hready = 1'b1;
    nxt_s.hresp = 1'b0;

    // ************************************
    // opcode 4 transfer decode
    // ************************************
    case (sub)
      4'h8: begin
        dDelta = b12 ? `INC_ONE : '0;
      end
      4'h9: begin
        dSp = b12 ? SP_MAIN : SP_MPROC;
        dDelta = `DEC_ONE;
      end
      4'hA: begin
        dSp = SP_CTRL;
        dLane = xb ? LN_HIGH : LN_WORD;
        dWide = ~xb;
        dDelta = b12 ? `INC_ONE : '0;
      end
      4'hB, 4'hF: begin
        dWr = sub[2];
        if (!xb) begin
          dSp = b12 ? SP_CTRL : SP_MPROC;
          dWide = 1'b1;
          dLane = LN_WORD;
          dDelta = `DEC_ONE;
        end else if (b12) begin
          dSp = SP_CTRL;
          dLane = LN_HIGH;
          dDelta = `DEC_ONE;
        end else begin
          dWide = 1'b1;
          dLane = LN_WORD;
          dDelta = `INC_TWO;
        end
      end
      4'hC: begin
        dWr = 1'b1;
        dDelta = b12 ? `INC_ONE : '0;
      end
      4'hD: begin
        dWr = 1'b1;
        dSp = b12 ? SP_MAIN : SP_MPROC;
        dLane = xb ? LN_HIGH : LN_LOW;
        dDelta = `DEC_ONE;
      end
      4'hE: begin
        dWr = 1'b1;
        dSp = SP_CTRL;
        if (xb) begin
          dLane = LN_HIGH;
          dDelta = b12 ? `INC_ONE : '0;
        end else begin
          dLane = LN_WORD;
          dWide = 1'b1;
          dDelta = b12 ? `DEC_ONE : '0;
        end
      end
      default: begin
        dOk = 1'b0;
      end
    endcase

    // ************************************
    // opcode 6 and 7 operands and alu
    // ************************************
    // byte ops work zero-extended so the carry lands in bit 8
    a = (op == 4'h6) ? {8'h00, tByte} : aW;
    if (sub == 4'h0 || sub == 4'h8) begin
      b = {12'h000, s_ff.instr[3:0]} + 16'h0001;
    end else if (op == 4'h6 || sub == 4'hA || sub == 4'hD) begin
      b = {8'h00, bSel};
    end else begin
      b = bW;
    end
    if (op == 4'h6) begin
      aluOk = !(sub == 4'hA || sub == 4'hD || sub == 4'hF);
    end else if (!(sub == 4'h0 || sub == 4'h8 || sub == 4'hA || sub == 4'hD)) begin
      aluOk = !b12 && sub != 4'hF;
    end
    cin = (sub == 4'h9 || sub == 4'hE) & s_ff.flags.carry;
    case (sub)
      4'h1: res = a ^ b;
      4'h2: res = b;
      4'h3: res = a | b;
      4'h4: begin
        aluWr = 1'b0;
        r17 = {1'b0, a} - {1'b0, b};
        res = r17[15:0];
      end
      4'h5: res = a & ~b;
      4'h6: res = a & b;
      4'h7: res = a | ~b;
      // shift left is the add case with both operands the same byte
      4'h0, 4'h9, 4'hB, 4'hD: begin
        arith = 1'b1;
        r17 = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
        res = r17[15:0];
      end
      default: begin
        arith = 1'b1;
        r17 = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
        res = r17[15:0];
      end
    endcase

    // ************************************
    // sequencer
    // ************************************
    unique case (s_ff.fsm)
      S_IDLE: begin
      end
      S_EXEC: begin
        nxt_s.fsm = S_IDLE;
        if (op == 4'h4 && dOk) begin
          nxt_s.fsm = S_MEM;
          nxt_s.mem.req = 1'b1;
          nxt_s.mem.write = dWr;
          nxt_s.mem.wide = dWide;
          nxt_s.mem.space = dSp;
          nxt_s.mem.addr = bW;
          nxt_s.mem.wdata = (dLane == LN_WORD) ? aW : {8'h00, (dLane == LN_HIGH) ? aW[15:8] : aW[7:0]};
          nxt_s.ldEn = ~dWr;
          nxt_s.ldReg = dataRegSel;
          nxt_s.ldLane = dLane;
          nxt_s.updEn = (dDelta != 16'h0000);
          nxt_s.updReg = addrRegSel;
          nxt_s.delta = dDelta;
        end else if (op == 4'h7 && xb) begin
          nxt_s.fsm = S_MEM;
          nxt_s.mem.req = 1'b1;
          nxt_s.mem.write = s_ff.instr[8];
          nxt_s.mem.wide = 1'b0;
          nxt_s.mem.space = SP_MPROC;
          nxt_s.mem.addr = {8'h00, s_ff.instr[7:0]};
          ld = s_ff.localStoreReg[{2'b00, s_ff.instr[10]}];
          nxt_s.mem.wdata = {8'h00, s_ff.instr[9] ? ld[15:8] : ld[7:0]};
          nxt_s.ldEn = ~s_ff.instr[8];
          nxt_s.ldReg = {2'b00, s_ff.instr[10]};
          nxt_s.ldLane = s_ff.instr[9] ? LN_HIGH : LN_LOW;
          nxt_s.updEn = 1'b0;
        end else if (op == 4'h5) begin
          nxt_s.flags.zero = (tByte & s_ff.instr[7:0]) == 8'h00;
          nxt_s.flags.ones = (tByte & s_ff.instr[7:0]) == s_ff.instr[7:0];
        end else if ((op == 4'h6 || op == 4'h7) && aluOk) begin
          if (arith) begin
            nxt_s.flags.carry = (op == 4'h6) ? r17[8] : r17[16];
          end
          nxt_s.flags.zero = (op == 4'h6) ? (res[7:0] == 8'h00) : (res == 16'h0000);
          if (!aluWr) begin
            nxt_s.flags.low = (op == 4'h6) ? r17[8] : r17[16];
          end else if (op == 4'h7) begin
            nxt_s.localStoreReg[dataRegSel] = res;
          end else if (xb) begin
            nxt_s.localStoreReg[dataRegSel][15:8] = res[7:0];
          end else begin
            nxt_s.localStoreReg[dataRegSel][7:0] = res[7:0];
          end
        end else begin
          nxt_s.invalid = 1'b1;
        end
      end
      S_MEM: begin
        if (memAns.ack) begin
          nxt_s.mem.req = 1'b0;
          nxt_s.fsm = S_IDLE;
          if (s_ff.updEn) begin
            nxt_s.localStoreReg[s_ff.updReg] = s_ff.localStoreReg[s_ff.updReg] + s_ff.delta;
          end
          // a load into the address register wins over its update
          if (s_ff.ldEn) begin
            unique case (s_ff.ldLane)
              LN_LOW: nxt_s.localStoreReg[s_ff.ldReg][7:0] = memAns.rdata[7:0];
              LN_HIGH: nxt_s.localStoreReg[s_ff.ldReg][15:8] = memAns.rdata[7:0];
              LN_WORD: nxt_s.localStoreReg[s_ff.ldReg] = memAns.rdata;
              default: nxt_s.localStoreReg[s_ff.ldReg] = memAns.rdata;
            endcase
          end
        end
      end
      default: begin
        nxt_s.fsm = S_IDLE;
      end
    endcase

    // ************************************
    // ahb-lite register access
    // ************************************
    // writes land in the data phase; ignored while an instruction runs
    if (s_ff.wrPend && s_ff.fsm == S_IDLE) begin
      if (s_ff.wrAddr == `INSTR_OFS) begin
        nxt_s.instr = hwdata[15:0];
        nxt_s.fsm = S_EXEC;
        nxt_s.invalid = 1'b0;
      end else if (s_ff.wrAddr[7:5] == `LOCAL_STORE_OFS >> 5) begin
        nxt_s.localStoreReg[s_ff.wrAddr[4:2]] = hwdata[15:0];
      end
    end
    nxt_s.wrPend = addrPh & hwrite;
    nxt_s.wrAddr = haddr[7:0];
    if (haddr[7:0] == `INSTR_OFS) begin
      rdv[15:0] = s_ff.instr;
    end else if (haddr[7:0] == `STAT_OFS) begin
      rdv[`ST_BUSY] = s_ff.fsm != S_IDLE;
      rdv[`ST_INVAL] = s_ff.invalid;
      rdv[`ST_CARRY] = s_ff.flags.carry;
      rdv[`ST_ZERO] = s_ff.flags.zero;
      rdv[`ST_ONES] = s_ff.flags.ones;
      rdv[`ST_LOW] = s_ff.flags.low;
    end else if (haddr[7:5] == `LOCAL_STORE_OFS >> 5) begin
      rdv[15:0] = s_ff.localStoreReg[haddr[4:2]];
    end
    nxt_s.hrdata = (addrPh && !hwrite) ? rdv : 32'h0000_0000;
  end

  // ************************************
  // state register
  // ************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.fsm <= S_IDLE;
      s_ff.instr <= `INSTR_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule
`default_nettype wire

/* File: test/service_decode_props.sv */
// port checker for the decoder, bound to it by module name
// assumes no instruction is written while the decoder is busy
`default_nettype none
module service_decode_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // storage side
  input wire decode_pkg::mem_req_t memReq
);
  timeunit 1ns;
  timeprecision 1ps;
  import decode_pkg::*;
  logic wrPend_ff, reqOld_ff, g4;
  logic [15:0] in_ff;
  logic [3:0] op, sub;
  assign op = in_ff[15:12];
  assign sub = in_ff[7:4];
  assign g4 = memReq.req && !reqOld_ff && op == 4'h4;
  // ****
  // instruction tracking
  // ****
  // the instruction is not a port, so it is recovered from the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_ff <= 1'h0;
      reqOld_ff <= 1'h0;
      in_ff <= 16'h0;
    end else begin
      wrPend_ff <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
      reqOld_ff <= memReq.req;
      if (wrPend_ff) begin
        in_ff <= hwdata[15:0];
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ld8;
    g4 && sub == 4'h8 |-> memReq.space == SP_MAIN && !memReq.write && !memReq.wide;
  endproperty
  a_ld8: assert property (p_ld8) else $error("byte load request wrong");
  property p_ld9;
    g4 && sub == 4'h9 |-> memReq.space == (in_ff[3] ? SP_MAIN : SP_MPROC) && !memReq.write;
  endproperty
  a_ld9: assert property (p_ld9) else $error("byte read space wrong");
  property p_ldA;
    g4 && sub == 4'hA |-> memReq.space == SP_CTRL && memReq.wide == !in_ff[11] && !memReq.write;
  endproperty
  a_ldA: assert property (p_ldA) else $error("control load request wrong");
  property p_stC;
    g4 && sub == 4'hC |-> memReq.space == SP_MAIN && memReq.write && !memReq.wide;
  endproperty
  a_stC: assert property (p_stC) else $error("byte store request wrong");
  property p_std;
    g4 && sub == 4'hD |-> memReq.space == (in_ff[3] ? SP_MAIN : SP_MPROC) && memReq.write && !memReq.wide;
  endproperty
  a_std: assert property (p_std) else $error("byte write request wrong");
  property p_stE;
    g4 && sub == 4'hE |-> memReq.space == SP_CTRL && memReq.write && memReq.wide == !in_ff[11];
  endproperty
  a_stE: assert property (p_stE) else $error("control store request wrong");
  property p_imm;
    memReq.req && !reqOld_ff && op == 4'h7 |-> in_ff[11] && memReq.space == SP_MPROC
      && memReq.write == in_ff[8] && memReq.addr[7:0] == in_ff[7:0];
  endproperty
  a_imm: assert property (p_imm) else $error("immediate transfer wrong");
  property p_bad;
    wrPend_ff && hwdata[15:12] == 4'h7 && !hwdata[11] && hwdata[7:4] == 4'hF |=> (!memReq.req) [*6];
  endproperty
  a_bad: assert property (p_bad) else $error("invalid code made a request");
endmodule
bind service_decode service_decode_props service_decode_props_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .memReq(memReq));
`default_nettype wire

/* File: test/mem_partner.sv */
// storage and processor register model behind the decoder's memory port
// assumes the request is held until the edge that samples the answer
`default_nettype none
module mem_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // answer delay in cycles
  input wire logic [1:0] lat,
  // request in, answer out
  input wire decode_pkg::mem_req_t memReq,
  output var decode_pkg::mem_ans_t memAns
);
  timeunit 1ns;
  timeprecision 1ps;
  import decode_pkg::*;
  logic [1:0] cnt_ff;
  // ****
  // answer logic
  // ****
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 2'h0;
      memAns <= '0;
    end else begin
      memAns.ack <= 1'h0;
      // data toggles outside the answer cycle so a late read shows up
      memAns.rdata <= ~memAns.rdata;
      cnt_ff <= 2'h0;
      if (memReq.req && !memAns.ack) begin
        cnt_ff <= cnt_ff + 2'h1;
        if (cnt_ff == lat) begin
          memAns.ack <= 1'h1;
          memAns.rdata <= memReq.addr ^ 16'h5A3C;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/service_proc_load_store_alu_decode_test.sv */
// self-checking bench for the service processor decoder
// assumes the decoder, its checker and the storage model are compiled
`default_nettype none
module service_proc_load_store_alu_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  import decode_pkg::*;
  logic ref_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdPend = 1'h0;
  logic hreadyout, hresp;
  logic [1:0] htrans = 2'h0, lat = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [63:0] e;
  logic [15:0] a, b, m, t, y;
  logic [7:0] d8;
  logic [63:0] rdQ[$];
  logic [35:0] mQ[$];
  // sub-op, byte select, bit12, space, write, wide, lane, signed step
  logic [15:0] tbl[10] = '{16'h8401, 16'h920F, 16'hAD11, 16'hB26F, 16'hB862,
    16'hCC81, 16'hDC9F, 16'hE5EF, 16'hF2EF, 16'hFD9F};
  int n_errors = 0, num_checks = 0, seed = 32'hCD7A3646;
  mem_req_t memReq;
  mem_ans_t memAns;
  service_decode service_decode_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memReq(memReq), .memAns(memAns));
  mem_partner mem_partner_inst (.ref_clk(ref_clk), .rst_n(rst_n), .lat(lat), .memReq(memReq), .memAns(memAns));
  // ****
  // tasks
  // ****
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // e holds a mask and an expected word; a zero mask skips the compare
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [63:0] ex);
    if (!w)
      rdQ.push_back(ex);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    xfer(1'h1, ad, {16'h0, d}, 64'h0);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] msk, input logic [15:0] ex);
    xfer(1'h0, ad, 32'h0, {msk, 16'h0, ex});
  endtask
  // busy is polled so a slow storage answer never races the next write
  task automatic exec(input logic [15:0] ins);
    wr(8'h00, ins);
    for (int i = 0; i < 40; i++) begin
      xfer(1'h0, 8'h04, 32'h0, 64'h0);
      if (r[0] === 1'h0)
        break;
    end
  endtask
  function automatic logic [15:0] alu(input logic [3:0] s, input logic [15:0] x, input logic [15:0] z);
    case (s)
      4'h0: return x + 16'h3;
      4'h1: return x ^ z;
      4'h2: return z;
      4'h3: return x | z;
      4'h5: return x & ~z;
      4'h6: return x & z;
      4'h7: return x | ~z;
      4'h8: return x - 16'h3;
      4'hB: return x + z;
      4'hC: return x - z;
      default: return x;
    endcase
  endfunction
  // ****
  // monitor, clock, watchdog
  // ****
  always @(posedge ref_clk) begin
    if (rdPend) begin
      e = rdQ.pop_front();
      if (e[63:32] != 32'h0)
        check({3'h0, hresp, hrdata & e[63:32]}, {4'h0, e[31:0]});
    end
    rdPend <= hsel && htrans[1] && hreadyout && !hwrite;
    if (memReq.req && memAns.ack)
      check({memReq.write, memReq.wide, memReq.space, memReq.addr,
        memReq.write ? memReq.wdata & (memReq.wide ? 16'hFFFF : 16'h00FF) : 16'h0}, mQ.pop_front());
  end
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rd(8'h04, 32'hFFFFFFFF, 16'h0);
    rd(8'h20, 32'hFFFFFFFF, 16'h0);
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 13; s++) begin
        if (s == 9 || s == 10)
          continue;
        a = 16'($random(seed));
        b = 16'($random(seed));
        wr(8'h44, a);
        wr(8'h48, b);
        exec({4'h6 + 4'(k), ~k[0], 3'h1, 4'(s), 4'h2});
        t = alu(4'(s), {8'h0, a[15:8]}, b);
        y = (k == 1) ? alu(4'(s), a, b) : {t[7:0], a[7:0]};
        rd(8'h44, 32'hFFFFFFFF, y);
      end
    end
    for (int i = 0; i < 10; i++) begin
      t = tbl[i];
      a = 16'($random(seed));
      b = 16'($random(seed));
      lat <= 2'($random(seed));
      wr(8'h4C, a);
      wr(8'h50, b);
      m = b ^ 16'h5A3C;
      d8 = t[4] ? a[15:8] : a[7:0];
      mQ.push_back({t[7:6], t[9:8], b, t[7] ? (t[6] ? a : {8'h0, d8}) : 16'h0});
      exec({4'h4, t[11], 3'h3, t[15:12], t[10], 3'h4});
      y = t[5] ? m : t[4] ? {m[7:0], a[7:0]} : {a[15:8], m[7:0]};
      rd(8'h4C, 32'hFFFFFFFF, t[7] ? a : y);
      rd(8'h50, 32'hFFFFFFFF, b + {{12{t[3]}}, t[3:0]});
    end
    wr(8'h44, a);
    mQ.push_back({2'h0, 2'h2, 16'h0033, 16'h0});
    exec(16'h7E33);
    y = {8'h0F, a[7:0]};
    rd(8'h44, 32'hFFFFFFFF, y);
    wr(8'h54, 16'h3C0F);
    exec(16'h5D3C);
    rd(8'h04, 32'h1B, 16'h10);
    exec(16'h55C0);
    rd(8'h04, 32'h1B, 16'h08);
    exec(16'h71F2);
    rd(8'h04, 32'h3, 16'h2);
    rd(8'h44, 32'hFFFFFFFF, y);
    check(36'(mQ.size()), 36'h0);
    close_out();
  end
endmodule
`default_nettype wire
